//--- hw/ccf_pkg.sv
/*
  Constants shared by the condition code and status flag logic: condition
  codes, status word bit positions, flag update selectors and field layout.
  Assumes a single CPU clock domain and a 16-bit data path.
*/
`default_nettype none
package ccf_pkg;
  // ==========================================================================
  // Status word layout
  localparam int unsigned ST_N = 0;
  localparam int unsigned ST_C = 1;
  localparam int unsigned ST_V = 2;
  localparam int unsigned ST_Z = 3;
  localparam int unsigned ST_E = 4;
  localparam int unsigned ST_U0 = 5;
  localparam int unsigned ST_U1 = 6;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] WORD_MIN_NEG = 16'h8000;
  localparam logic [7:0] BYTE_MIN_NEG = 8'h80;

  // ==========================================================================
  // Four-bit condition codes
  localparam logic [3:0] CC_ALWAYS = 4'h0;
  localparam logic [3:0] NOT_EQUAL_NOT_TABLE_END = 4'h1;
  localparam logic [3:0] CC_Z = 4'h2;
  localparam logic [3:0] CC_NZ = 4'h3;
  localparam logic [3:0] CC_V = 4'h4;
  localparam logic [3:0] CC_NV = 4'h5;
  localparam logic [3:0] CC_N = 4'h6;
  localparam logic [3:0] CC_NN = 4'h7;
  localparam logic [3:0] CC_C = 4'h8;
  localparam logic [3:0] CC_NC = 4'h9;
  localparam logic [3:0] SIGNED_GT_COND = 4'hA;
  localparam logic [3:0] SIGNED_LE_COND = 4'hB;
  localparam logic [3:0] SIGNED_LT_COND = 4'hC;
  localparam logic [3:0] SIGNED_GE_COND = 4'hD;
  localparam logic [3:0] UNSIGNED_GT_COND = 4'hE;
  localparam logic [3:0] UNSIGNED_LE_COND = 4'hF;

  // ==========================================================================
  // Five-bit extended codes for the user flags (odd values only)
  localparam logic [4:0] XC_NUSR0 = 5'h01;
  localparam logic [4:0] XC_NUSR1 = 5'h03;
  localparam logic [4:0] XC_USER_FLAG_ZERO = 5'h05;
  localparam logic [4:0] XC_USER_FLAG_ONE = 5'h07;

  // ==========================================================================
  // Per-flag update selector
  typedef enum logic [2:0] {
    CCF_FL_KEEP, CCF_FL_ZERO, CCF_FL_STD, CCF_FL_NOR, CCF_FL_AND,
    CCF_FL_OR, CCF_FL_XOR, CCF_FL_BIT
  } ccf_flag_sel_t;

  // Destination width when the status word is the target
  typedef enum logic [1:0] {
    CCF_DST_NONE, CCF_DST_WORD, CCF_DST_BYTE, CCF_DST_BITS
  } ccf_dst_t;

  // ==========================================================================
  // Instruction field layout
  localparam logic [31:0] TRAP_FIXED_MASK = 32'h0000_0100;
  localparam int unsigned OPC_LSB = 0;
  localparam int unsigned NIB_N_LSB = 12;
  localparam int unsigned NIB_M_LSB = 8;
  localparam int unsigned BYTE2_LSB = 16;
  localparam int unsigned BYTE3_LSB = 24;
  localparam int unsigned TRAP_LSB = 9;
  localparam int unsigned IDX_LSB = 8;
endpackage : ccf_pkg
`default_nettype wire

//--- hw/ccf_cond_eval.sv
/*
  Combinational condition evaluator for the 4-bit and 5-bit condition
  fields. Assumes flags arrive already forwarded from the status path.
*/
`timescale 1ns/10ps
`default_nettype none
module ccf_cond_eval
  import ccf_pkg::*;
(
  input wire logic [4:0] cond_field,
  input wire logic ext_field,
  input wire logic abs_jump_call,
  input wire logic [15:0] flags,
  output logic cond_true
);
  import ccf_pkg::*;
  // ==========================================================================
  // Condition decode
  logic fn, fc, fv, fz, fe, u0, u1;
  logic [3:0] base;
  logic base_true;
  logic user_true;
  logic user_code;
  assign fn = flags[ST_N];
  assign fc = flags[ST_C];
  assign fv = flags[ST_V];
  assign fz = flags[ST_Z];
  assign fe = flags[ST_E];
  assign u0 = flags[ST_U0];
  assign u1 = flags[ST_U1];
  // Extended codes are twice the short code, so drop the low bit.
  assign base = ext_field ? cond_field[4:1] : cond_field[3:0];
  assign user_code = ext_field && cond_field[0];

  // One table serves both widths.
  always_comb begin
    case (base)
      CC_ALWAYS: base_true = 1'b1;
      NOT_EQUAL_NOT_TABLE_END: base_true = !(fz || fe);
      CC_Z: base_true = fz;
      CC_NZ: base_true = !fz;
      CC_V: base_true = fv;
      CC_NV: base_true = !fv;
      CC_N: base_true = fn;
      CC_NN: base_true = !fn;
      CC_C: base_true = fc;
      CC_NC: base_true = !fc;
      SIGNED_GT_COND: base_true = !(fz || (fn ^ fv));
      SIGNED_LE_COND: base_true = fz || (fn ^ fv);
      SIGNED_LT_COND: base_true = fn ^ fv;
      SIGNED_GE_COND: base_true = !(fn ^ fv);
      UNSIGNED_GT_COND: base_true = !(fz || fc);
      UNSIGNED_LE_COND: base_true = fz || fc;
      default: base_true = 1'b0;
    endcase
  end

  // User tests are legal only on absolute conditional jumps and calls.
  always_comb begin
    case (cond_field)
      XC_NUSR0: user_true = !u0;
      XC_NUSR1: user_true = !u1;
      XC_USER_FLAG_ZERO: user_true = u0;
      XC_USER_FLAG_ONE: user_true = u1;
      default: user_true = 1'b0;
    endcase
  end

  assign cond_true = user_code ? (abs_jump_call && user_true) : base_true;
endmodule : ccf_cond_eval
`default_nettype wire

//--- hw/ccf_field_dec.sv
/*
  Instruction field extractor. Assumes the fetched instruction arrives as
  a 32-bit little-endian image, opcode in the lowest byte.
*/
`timescale 1ns/10ps
`default_nettype none
module ccf_field_dec
  import ccf_pkg::*;
(
  input wire logic [31:0] instr,
  output logic [7:0] opcode,
  output logic [3:0] reg_n,
  output logic [3:0] reg_m,
  output logic [1:0] ptr_reg,
  output logic [15:0] wide_immediate,
  output logic [7:0] byte_immediate,
  output logic [6:0] trap_number_field,
  output logic trap_form_ok,
  output logic [7:0] src_bit_word,
  output logic [3:0] src_bit_pos,
  output logic [7:0] dst_bit_word,
  output logic [3:0] dst_bit_pos,
  output logic [15:0] rel_byte_offset
);
  import ccf_pkg::*;
  // ==========================================================================
  // Field extraction
  assign opcode = instr[OPC_LSB +: 8];
  assign reg_n = instr[NIB_N_LSB +: 4];
  assign reg_m = instr[NIB_M_LSB +: 4];
  assign ptr_reg = instr[IDX_LSB +: 2];
  // Low byte first, then high byte.
  assign wide_immediate = {instr[BYTE3_LSB +: 8], instr[BYTE2_LSB +: 8]};
  // Only the first byte counts; the second is never looked at.
  assign byte_immediate = instr[BYTE2_LSB +: 8];
  assign trap_number_field = instr[TRAP_LSB +: 7];
  assign trap_form_ok = (instr & TRAP_FIXED_MASK) == 32'h0000_0000;
  assign src_bit_word = instr[IDX_LSB +: 8];
  assign dst_bit_word = instr[BYTE2_LSB +: 8];
  assign src_bit_pos = instr[BYTE3_LSB + 4 +: 4];
  assign dst_bit_pos = instr[BYTE3_LSB +: 4];
  // Offset counts words, so the byte distance is doubled.
  assign rel_byte_offset = {{7{instr[IDX_LSB + 7]}}, instr[IDX_LSB +: 8], 1'b0};
endmodule : ccf_field_dec
`default_nettype wire

//--- hw/ccf_flag_unit.sv
/*
  Status flag unit: holds the status word, computes standard flags for
  additions, handles status word writes and evaluates branch conditions.
  Assumes the execute stage presents one instruction per valid cycle.
*/
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Short field: 0 always, 2/3 zero, 4/5 overflow, 6/7 negative, 8/9 carry.
// - Extended field codes each flag condition at twice the short value.
// - Unsigned le when zero or carry; unsigned gt when neither.
// - Signed lt when negative xor overflow; signed ge otherwise.
// - Signed le when zero or (n xor v); signed gt otherwise.
// - Not-equal-not-table-end true only with zero and table-end clear.
// - Odd extended codes 1 to 7 test user flags, only for absolute jump/call.
// - Standard negative flag takes the result's top bit.
// - Standard carry, overflow and zero follow the operation outcome.
// - Table-end set when source is the most negative value.
// - A flag may keep its value or be forced to zero.
// - Bit operations load NOR, AND, OR, XOR, or the bit itself or its inverse.
// - A word write to the status word replaces it whole.
// - A byte write sets the addressed byte and clears the other.
// - Bit writes touch only selected bits; others keep old values.
// - Nibbles n and m select registers; two bits select a pointer.
// - Wide addresses and immediates come low byte first.
// - A byte immediate uses the first byte only.
// - Trap number is seven bits ahead of a fixed zero bit.
// - Bit operands are an 8-bit word address plus 4-bit position.
// - Relative branch offset is eight bits counted in words.
// - Word addition overflow when the signed result does not fit.
module ccf_flag_unit
  import ccf_pkg::*;
#(
  parameter int unsigned DATA_W = 16
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic exec_valid,
  input wire logic is_add,
  input wire logic add_with_carry,
  input wire logic byte_op,
  input wire logic [DATA_W-1:0] op_dst,
  input wire logic [DATA_W-1:0] op_src,
  input wire logic [DATA_W-1:0] ext_result,
  input wire logic ext_carry,
  input wire logic ext_overflow,
  input wire ccf_pkg::ccf_flag_sel_t sel_n,
  input wire ccf_pkg::ccf_flag_sel_t sel_c,
  input wire ccf_pkg::ccf_flag_sel_t sel_v,
  input wire ccf_pkg::ccf_flag_sel_t sel_z,
  input wire ccf_pkg::ccf_flag_sel_t sel_e,
  input wire logic bit_a,
  input wire logic bit_b,
  input wire logic bit_invert,
  input wire ccf_pkg::ccf_dst_t status_dst,
  input wire logic status_high_byte,
  input wire logic [DATA_W-1:0] status_bit_mask,
  input wire logic [31:0] instr,
  input wire logic [4:0] cond_field,
  input wire logic ext_field,
  input wire logic abs_jump_call,
  output logic cond_true,
  output logic [DATA_W-1:0] status_word,
  output logic [DATA_W-1:0] add_result,
  output logic double_word,
  output logic [3:0] reg_n,
  output logic [3:0] reg_m,
  output logic [1:0] ptr_reg,
  output logic [15:0] wide_immediate,
  output logic [7:0] byte_immediate,
  output logic [6:0] trap_number_field,
  output logic trap_form_ok,
  output logic [7:0] src_bit_word,
  output logic [3:0] src_bit_pos,
  output logic [7:0] dst_bit_word,
  output logic [3:0] dst_bit_pos,
  output logic [15:0] rel_byte_offset
);
  import ccf_pkg::*;

  // ==========================================================================
  // Instruction fields
  logic [7:0] opcode;

  ccf_field_dec u_dec (
    .instr(instr),
    .opcode(opcode),
    .reg_n(reg_n),
    .reg_m(reg_m),
    .ptr_reg(ptr_reg),
    .wide_immediate(wide_immediate),
    .byte_immediate(byte_immediate),
    .trap_number_field(trap_number_field),
    .trap_form_ok(trap_form_ok),
    .src_bit_word(src_bit_word),
    .src_bit_pos(src_bit_pos),
    .dst_bit_word(dst_bit_word),
    .dst_bit_pos(dst_bit_pos),
    .rel_byte_offset(rel_byte_offset)
  );

  // Opcodes with low nibble 2..7 carry a 16-bit address or immediate; the
  // short register and immediate forms (0, 1, 8, 9) are single word.
  assign double_word = (opcode[3:0] >= 4'h2) && (opcode[3:0] <= 4'h7);

  // ==========================================================================
  // Adder with byte and word views
  logic carry_in;
  logic [DATA_W:0] sum_full;
  logic [8:0] sum_byte;
  logic [DATA_W-1:0] add_res;
  logic add_c, add_v, add_n, add_z;
  assign carry_in = add_with_carry && status_word[ST_C];
  assign sum_full = {1'b0, op_dst} + {1'b0, op_src} + {{DATA_W{1'b0}}, carry_in};
  assign sum_byte = {1'b0, op_dst[7:0]} + {1'b0, op_src[7:0]} + {8'h00, carry_in};
  assign add_res = byte_op ? {{(DATA_W-8){1'b0}}, sum_byte[7:0]} : sum_full[DATA_W-1:0];
  assign add_c = byte_op ? sum_byte[8] : sum_full[DATA_W];
  // Overflow when both operands share a sign the result lacks.
  assign add_v = byte_op ?
    ((op_dst[7] == op_src[7]) && (sum_byte[7] != op_dst[7])) :
    ((op_dst[DATA_W-1] == op_src[DATA_W-1]) &&
     (sum_full[DATA_W-1] != op_dst[DATA_W-1]));

  // ==========================================================================
  // Standard flag sources
  logic [DATA_W-1:0] res;
  logic std_n, std_c, std_v, std_z, std_e, raw_z;
  assign res = is_add ? add_res : ext_result;
  assign add_n = byte_op ? res[7] : res[DATA_W-1];
  assign std_n = add_n;
  assign std_c = is_add ? add_c : ext_carry;
  assign std_v = is_add ? add_v : ext_overflow;
  assign raw_z = byte_op ? (res[7:0] == 8'h00) : (res == {DATA_W{1'b0}});
  // With carry in, zero also needs the old zero flag, for chained adds.
  assign add_z = (is_add && add_with_carry) ? (raw_z && status_word[ST_Z]) : raw_z;
  assign std_z = add_z;
  assign std_e = byte_op ? (op_src[7:0] == BYTE_MIN_NEG) :
                 (op_src == WORD_MIN_NEG[DATA_W-1:0]);

  // ==========================================================================
  // Per-flag selection
  logic bit_val;
  ccf_flag_sel_t sel [5];
  logic std_v_arr [5];
  logic [4:0] new_flag;
  int unsigned pos [5];
  assign bit_val = bit_a ^ bit_invert;
  assign sel[0] = sel_n;
  assign sel[1] = sel_c;
  assign sel[2] = sel_v;
  assign sel[3] = sel_z;
  assign sel[4] = sel_e;
  assign std_v_arr[0] = std_n;
  assign std_v_arr[1] = std_c;
  assign std_v_arr[2] = std_v;
  assign std_v_arr[3] = std_z;
  assign std_v_arr[4] = std_e;
  assign pos[0] = ST_N;
  assign pos[1] = ST_C;
  assign pos[2] = ST_V;
  assign pos[3] = ST_Z;
  assign pos[4] = ST_E;

  // One selector per condition flag.
  for (genvar gi = 0; gi < 5; gi++) begin : g_flag
    always_comb begin
      case (sel[gi])
        CCF_FL_KEEP: new_flag[gi] = status_word[pos[gi]];
        CCF_FL_ZERO: new_flag[gi] = 1'b0;
        CCF_FL_STD: new_flag[gi] = std_v_arr[gi];
        CCF_FL_NOR: new_flag[gi] = !(bit_a || bit_b);
        CCF_FL_AND: new_flag[gi] = bit_a && bit_b;
        CCF_FL_OR: new_flag[gi] = bit_a || bit_b;
        CCF_FL_XOR: new_flag[gi] = bit_a ^ bit_b;
        CCF_FL_BIT: new_flag[gi] = bit_val;
        default: new_flag[gi] = status_word[pos[gi]];
      endcase
    end
  end

  logic [DATA_W-1:0] flag_word;
  always_comb begin
    flag_word = status_word;
    flag_word[ST_N] = new_flag[0];
    flag_word[ST_C] = new_flag[1];
    flag_word[ST_V] = new_flag[2];
    flag_word[ST_Z] = new_flag[3];
    flag_word[ST_E] = new_flag[4];
  end

  // ==========================================================================
  // Status word destination handling
  logic [DATA_W-1:0] byte_word;
  logic [DATA_W-1:0] bits_word;
  logic [DATA_W-1:0] next_status;
  assign byte_word = status_high_byte ? {res[7:0], 8'h00} :
                     {{(DATA_W-8){1'b0}}, res[7:0]};
  assign bits_word = (status_word & ~status_bit_mask) |
                     (res & status_bit_mask);

  // A status write overrides the computed flags entirely.
  always_comb begin
    case (status_dst)
      CCF_DST_WORD: next_status = res;
      CCF_DST_BYTE: next_status = byte_word;
      CCF_DST_BITS: next_status = bits_word;
      default: next_status = flag_word;
    endcase
  end

  // Status register; a cycle without a valid instruction holds it.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_word <= STATUS_RESET;
      add_result <= '0;
    end else if (exec_valid) begin
      status_word <= next_status;
      add_result <= res;
    end
  end

  // ==========================================================================
  // Condition evaluation with forwarding
  logic [DATA_W-1:0] eval_flags;
  // Forwarding avoids a stale-flag bubble when a branch follows its setter.
  assign eval_flags = exec_valid ? next_status : status_word;

  ccf_cond_eval u_cond (
    .cond_field(cond_field),
    .ext_field(ext_field),
    .abs_jump_call(abs_jump_call),
    .flags(eval_flags),
    .cond_true(cond_true)
  );

  // ==========================================================================
  // Checks
  a_word_write_whole: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exec_valid && status_dst == CCF_DST_WORD |=> status_word == $past(res))
    else $error("status word not replaced by word result");
  a_byte_write_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exec_valid && status_dst == CCF_DST_BYTE && !status_high_byte
    |=> status_word[15:8] == 8'h00)
    else $error("other status byte not cleared");
  a_bits_keep_rest: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exec_valid && status_dst == CCF_DST_BITS
    |=> ((status_word ^ $past(status_word)) & ~$past(status_bit_mask)) == 16'h0000)
    else $error("unselected status bits changed");
  a_keep_flag_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exec_valid && status_dst == CCF_DST_NONE && sel_c == CCF_FL_KEEP
    |=> $stable(status_word[ST_C]))
    else $error("kept carry flag changed");
  a_zero_flag_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exec_valid && status_dst == CCF_DST_NONE && sel_v == CCF_FL_ZERO
    |=> !status_word[ST_V])
    else $error("forced-zero overflow flag is set");
  a_std_neg_msb: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exec_valid && status_dst == CCF_DST_NONE && sel_n == CCF_FL_STD && !byte_op
    |=> status_word[ST_N] == add_result[DATA_W-1])
    else $error("negative flag differs from result msb");
  a_table_end_word: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exec_valid && status_dst == CCF_DST_NONE && sel_e == CCF_FL_STD && !byte_op
    |=> status_word[ST_E] == ($past(op_src) == 16'h8000))
    else $error("table end flag wrong for word source");
  a_hold_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !exec_valid |=> $stable(status_word))
    else $error("status word changed without instruction");
  a_net_cond: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !exec_valid && !ext_field && cond_field[3:0] == NOT_EQUAL_NOT_TABLE_END
    |-> cond_true == !(status_word[ST_Z] || status_word[ST_E]))
    else $error("not-equal-not-end condition wrong");
  a_user_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ext_field && cond_field[0] && !abs_jump_call |-> !cond_true)
    else $error("user flag test accepted outside absolute jump or call");
endmodule : ccf_flag_unit
`default_nettype wire

//--- sim/ccf_fetch_model.sv
/*
  Fetch stage stand-in: assembles the instruction image from bytes in
  memory order. Assumes the bench offers bytes just after a rising edge.
*/
`timescale 1ns/10ps
`default_nettype none
module ccf_fetch_model (
  input wire logic ref_clk,
  input wire logic load,
  input wire logic [7:0] byte0,
  input wire logic [7:0] byte1,
  input wire logic [7:0] byte2,
  input wire logic [7:0] byte3,
  output logic [31:0] instr = 32'h0000_0000
);
  // ==========================================================================
  // The first fetched byte lands lowest, so wide fields read low byte first.
  always @(posedge ref_clk) begin
    if (load) begin
      instr <= {byte3, byte2, byte1, byte0};
    end
  end
endmodule // ccf_fetch_model
`default_nettype wire

//--- sim/test_cond_code_flag_logic.sv
/*
  Self-checking bench for the flag unit: random operations, status word
  writes, branch conditions and field decoding. Assumes one 200 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
module test_cond_code_flag_logic;
  import ccf_pkg::*;
  logic ref_clk = 1'b0, rst_n = 1'b0, exec_valid = 1'b0, is_add = 1'b0;
  logic add_with_carry = 1'b0, byte_op = 1'b0, ext_carry = 1'b0;
  logic ext_overflow = 1'b0, bit_a = 1'b0, bit_b = 1'b0, bit_invert = 1'b0;
  logic status_high_byte = 1'b0, ext_field = 1'b0, abs_jump_call = 1'b0;
  logic load = 1'b0, cond_true, double_word, trap_form_ok;
  logic [15:0] op_dst = 16'h0000, op_src = 16'h0000, ext_result = 16'h0000;
  logic [15:0] status_bit_mask = 16'h0000, status_word, add_result;
  logic [15:0] wide_immediate, rel_byte_offset, old = 16'h0000;
  logic [4:0] cond_field = 5'h00;
  logic [7:0] by[4] = '{8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] byte_immediate, src_bit_word, dst_bit_word;
  logic [31:0] instr, seed = 32'd94;
  logic [3:0] reg_n, reg_m, src_bit_pos, dst_bit_pos;
  logic [1:0] ptr_reg;
  logic [6:0] trap_number_field;
  ccf_flag_sel_t sel[5] = '{CCF_FL_STD, CCF_FL_STD, CCF_FL_STD, CCF_FL_STD,
    CCF_FL_STD};
  ccf_dst_t status_dst = CCF_DST_NONE;
  int miscompares = 0, checks = 0, cyc = 0;

  // ==========================================================================
  // Clock, cycle ceiling and the device.
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 4000) begin
      miscompares++;
      give_verdict();
    end
  end
  ccf_fetch_model u_ccf_fetch_model (.ref_clk(ref_clk), .load(load),
    .byte0(by[0]), .byte1(by[1]), .byte2(by[2]), .byte3(by[3]),
    .instr(instr));
  ccf_flag_unit u_ccf_flag_unit (.ref_clk(ref_clk), .rst_n(rst_n),
    .exec_valid(exec_valid), .is_add(is_add),
    .add_with_carry(add_with_carry), .byte_op(byte_op), .op_dst(op_dst),
    .op_src(op_src), .ext_result(ext_result), .ext_carry(ext_carry),
    .ext_overflow(ext_overflow), .sel_n(sel[0]), .sel_c(sel[1]),
    .sel_v(sel[2]), .sel_z(sel[3]), .sel_e(sel[4]), .bit_a(bit_a),
    .bit_b(bit_b), .bit_invert(bit_invert), .status_dst(status_dst),
    .status_high_byte(status_high_byte), .status_bit_mask(status_bit_mask),
    .instr(instr), .cond_field(cond_field), .ext_field(ext_field),
    .abs_jump_call(abs_jump_call), .cond_true(cond_true),
    .status_word(status_word), .add_result(add_result),
    .double_word(double_word), .reg_n(reg_n), .reg_m(reg_m),
    .ptr_reg(ptr_reg), .wide_immediate(wide_immediate),
    .byte_immediate(byte_immediate), .trap_number_field(trap_number_field),
    .trap_form_ok(trap_form_ok), .src_bit_word(src_bit_word),
    .src_bit_pos(src_bit_pos), .dst_bit_word(dst_bit_word),
    .dst_bit_pos(dst_bit_pos), .rel_byte_offset(rel_byte_offset));

  // ==========================================================================
  // Helpers: random source, comparison, verdict and expectation functions.
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Reference condition table; odd extended codes only test user flags,
  // and odd codes above 7 name no test, so they are never true.
  function automatic logic cond_ref(logic [4:0] c, logic x, logic ab,
    logic [15:0] f);
    logic n, cy, v, z, e;
    logic [3:0] k;
    {e, z, v, cy, n} = f[4:0];
    if (x && c[0]) return ab && (c[4:3] == 2'b00) &&
      (c[2] ? f[5 + c[1]] : !f[5 + c[1]]);
    k = x ? c[4:1] : c[3:0];
    case (k)
      4'h0: return 1'b1;
      4'h1: return !(z | e);
      4'h2, 4'h3: return z ^ k[0];
      4'h4, 4'h5: return v ^ k[0];
      4'h6, 4'h7: return n ^ k[0];
      4'h8, 4'h9: return cy ^ k[0];
      4'hA, 4'hB: return (z | (n ^ v)) ^ !k[0];
      4'hC, 4'hD: return (n ^ v) ^ k[0];
      default: return (z | cy) ^ !k[0];
    endcase
  endfunction
  // Presents a random condition and compares against the given flags.
  task automatic try_cond(input logic [15:0] f);
    cond_field = xs();
    ext_field = xs();
    abs_jump_call = xs();
    if (!ext_field) cond_field[4] = 1'b0;
    #1 chk(cond_true, cond_ref(cond_field, ext_field, abs_jump_call, f));
  endtask

  // ==========================================================================
  // One random instruction: flags from every selector, then status writes.
  task automatic run_op();
    logic [16:0] s;
    logic [8:0] sb;
    logic [15:0] res, nx;
    logic [4:0] sf;
    logic ci;
    @(posedge ref_clk);
    #1;
    is_add = xs();
    add_with_carry = is_add & xs();
    op_dst = xs();
    op_src = (xs() % 6 == 0) ? 16'h8000 : xs();
    if (xs() % 6 == 0) op_src[7:0] = 8'h80;
    ext_result = (xs() % 5 == 0) ? 16'h0000 : xs();
    {ext_carry, ext_overflow, bit_a, bit_b, bit_invert} = xs();
    foreach (sel[i]) sel[i] = ccf_flag_sel_t'(xs());
    status_dst = ccf_dst_t'(xs() % 8 > 3 ? 0 : xs());
    byte_op = status_dst == CCF_DST_BYTE ? 1'b1 :
      (status_dst == CCF_DST_WORD ? 1'b0 : xs());
    status_high_byte = xs();
    status_bit_mask = xs();
    ci = add_with_carry & old[ST_C];
    s = op_dst + op_src + ci;
    sb = op_dst[7:0] + op_src[7:0] + ci;
    // Byte sums come back zero-extended from the adder.
    res = !is_add ? ext_result : (byte_op ? {8'h00, sb[7:0]} : s[15:0]);
    sf[0] = byte_op ? res[7] : res[15];
    sf[1] = !is_add ? ext_carry : (byte_op ? sb[8] : s[16]);
    sf[2] = !is_add ? ext_overflow : (byte_op ?
      (op_dst[7] == op_src[7] && res[7] != op_dst[7]) :
      (op_dst[15] == op_src[15] && res[15] != op_dst[15]));
    sf[3] = (byte_op ? res[7:0] == 8'h00 : res == 16'h0000) &&
      (!add_with_carry || old[ST_Z]);
    sf[4] = byte_op ? op_src[7:0] == 8'h80 : op_src == 16'h8000;
    nx = old;
    foreach (sel[i]) begin
      case (sel[i])
        CCF_FL_KEEP: nx[i] = old[i];
        CCF_FL_ZERO: nx[i] = 1'b0;
        CCF_FL_STD: nx[i] = sf[i];
        CCF_FL_NOR: nx[i] = !(bit_a | bit_b);
        CCF_FL_AND: nx[i] = bit_a & bit_b;
        CCF_FL_OR: nx[i] = bit_a | bit_b;
        CCF_FL_XOR: nx[i] = bit_a ^ bit_b;
        default: nx[i] = bit_a ^ bit_invert;
      endcase
    end
    case (status_dst)
      CCF_DST_WORD: nx = res;
      CCF_DST_BYTE: nx = status_high_byte ? {res[7:0], 8'h00} :
        {8'h00, res[7:0]};
      CCF_DST_BITS: nx = (old & ~status_bit_mask) |
        (res & status_bit_mask);
      default: ;
    endcase
    exec_valid = 1'b1;
    try_cond(nx);
    @(posedge ref_clk);
    #1 exec_valid = 1'b0;
    chk(status_word, nx);
    chk(add_result, res);
    old = nx;
    try_cond(old);
  endtask

  // ==========================================================================
  // Random instruction images through the fetch model, fields compared.
  task automatic run_fields();
    logic [31:0] i;
    @(posedge ref_clk);
    #1;
    foreach (by[k]) by[k] = xs();
    load = 1'b1;
    @(posedge ref_clk);
    #1 load = 1'b0;
    i = {by[3], by[2], by[1], by[0]};
    chk(double_word, i[3:0] inside {[4'h2:4'h7]});
    chk({reg_n, reg_m, ptr_reg}, {i[15:8], i[9:8]});
    chk(wide_immediate, {i[31:24], i[23:16]});
    chk(byte_immediate, i[23:16]);
    chk({trap_number_field, trap_form_ok}, {i[15:9], !i[8]});
    chk({src_bit_word, src_bit_pos}, {i[15:8], i[31:28]});
    chk({dst_bit_word, dst_bit_pos}, {i[23:16], i[27:24]});
    chk(rel_byte_offset, {{7{i[15]}}, i[15:8], 1'b0});
  endtask

  // ==========================================================================
  // Main sequence: reset, random operations, then field decoding.
  initial begin
    repeat (12) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    chk({status_word, add_result}, {STATUS_RESET, 16'h0000});
    $display("reset test done");
    repeat (400) run_op();
    $display("flag and condition test done");
    repeat (80) run_fields();
    $display("field test done");
    give_verdict();
  end
endmodule // test_cond_code_flag_logic
`default_nettype wire
